// >>> bench/abc_alarm_batch_test.sv
// Self-checking testbench for the alarm response and batch totaliser block
`timescale 1ns/1ps
module abc_alarm_batch_test;
  import abc_pkg::*;
  localparam int SC = 10;
  logic        core_clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        par_wr = 1'b0, par_rd = 1'b0, cond = 1'b0, err_s = 1'b0, warn_s = 1'b0, sw = 1'b0, upd = 1'b0;
  logic        hit = 1'b0, ext = 1'b0;
  logic [15:0] addr = 16'h0000, sp_in = 16'h0100;
  logic [31:0] wdata = 32'h0, sum = 32'h0, q;
  logic [31:0] par_rdata_out, upd_value_out, upd_density_out, upd_limit_out;
  logic        par_ack_out, alarm_out, upd_req_out, upd_custom_out;
  logic [15:0] setpoint_out;
  logic [7:0]  alarm_info_out;
  int          err_count = 0;
  int          checks_done = 0;
  int          n;
  always #2.5 core_clk_in = ~core_clk_in;
  abc_alarm_batch #(.SEC_CYC(SC)) DUT (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .par_wr_in(par_wr), .par_rd_in(par_rd),
    .par_addr_in(addr), .par_wdata_in(wdata), .alarm_cond_in(cond), .err_set_in(err_s),
    .warn_set_in(warn_s), .clr_switch_in(sw), .clr_ext_in(ext), .upd_in(upd),
    .increment_in(32'h0), .sum_in(sum), .limit_hit_in(hit), .setpoint_in(sp_in),
    .par_rdata_out(par_rdata_out), .par_ack_out(par_ack_out), .setpoint_out(setpoint_out),
    .alarm_out(alarm_out), .alarm_info_out(alarm_info_out), .upd_req_out(upd_req_out),
    .upd_value_out(upd_value_out), .upd_density_out(upd_density_out),
    .upd_custom_out(upd_custom_out), .upd_limit_out(upd_limit_out));
  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One-cycle strobe; ack and read data are looked at together
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    int i;
    @(negedge core_clk_in);
    par_wr = w; par_rd = !w; addr = a; wdata = d;
    @(negedge core_clk_in);
    par_wr = 1'b0; par_rd = 1'b0;
    for (i = 0; i < 4 && par_ack_out !== 1'b1; i++) @(negedge core_clk_in);
    if (i == 4) begin err_count++; results(); end
    q = par_rdata_out;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [15:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    cmp(nm, e, q);
  endtask
  task automatic wait_al(input logic v, input int lim);
    for (n = 0; n < lim && alarm_out !== v; n++) @(negedge core_clk_in);
    if (n == lim) begin err_count++; results(); end
    // Setpoint follows the alarm one cycle later
    @(negedge core_clk_in);
  endtask
  task automatic pulse_upd(input logic [31:0] s, input logic e);
    sum = s;
    @(negedge core_clk_in); upd = 1'b1;
    @(negedge core_clk_in); upd = 1'b0;
    cmp("upd req", {31'h0, e}, {31'h0, upd_req_out});
    repeat (3) @(negedge core_clk_in);
  endtask
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge core_clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    rd("alm act", ABC_ADR_ALM_ACT, 32'h0);
    rd("alm safe", ABC_ADR_ALM_SAFE, 32'h0);
    rd("alm clr", ABC_ADR_ALM_CLR, 32'hf);
    rd("tot act", ABC_ADR_TOT_ACT, 32'h0);
    rd("tot safe", ABC_ADR_TOT_SAFE, 32'h0);
    rd("tot mode", ABC_ADR_TOT_MODE, 32'h0);
    rd("tot clr", ABC_ADR_TOT_CLR, 32'h7);
    rd("limit", ABC_ADR_LIMIT, 32'h0);
    rd("unmapped", 16'h1234, 32'h0);
    wr(ABC_ADR_TOT_MODE, 32'h3);
    rd("mode 3 ignored", ABC_ADR_TOT_MODE, 32'h0);
    wr(ABC_ADR_TOT_VAL, 32'h4c000000);
    rd("value clip", ABC_ADR_TOT_VAL, ABC_TOT_MAX);
    wr(ABC_ADR_LIMIT, 32'h4c000000);
    rd("limit clip", ABC_ADR_LIMIT, ABC_LIMIT_MAX);
    cmp("upd limit", ABC_LIMIT_MAX, upd_limit_out);
    tend("defaults");
    // Alarm with auto clear and safe setpoint
    wr(ABC_ADR_ALM_ACT, 32'h1);
    wr(ABC_ADR_ALM_SAFE, 32'h1234);
    cond = 1'b1;
    wait_al(1'b1, 20);
    cmp("alarm sp", 32'h1234, {16'h0, setpoint_out});
    cond = 1'b0;
    wait_al(1'b0, 20);
    cmp("sp restored", 32'h0100, {16'h0, setpoint_out});
    tend("alarm auto");
    // Command-only clear with delay of two seconds
    wr(ABC_ADR_ALM_CLR, 32'h4);
    wr(ABC_ADR_ALM_DLY, 32'h2);
    cond = 1'b1;
    wait_al(1'b1, 60);
    cmp("delay window", 32'h1, {31'h0, n >= 2 * SC && n <= 2 * SC + 8});
    cond = 1'b0;
    repeat (60) @(negedge core_clk_in);
    sw = 1'b1; ext = 1'b1;
    @(negedge core_clk_in); sw = 1'b0; ext = 1'b0;
    repeat (3) @(negedge core_clk_in);
    cmp("alarm held", 32'h1, {31'h0, alarm_out});
    wr(ABC_ADR_RESET_CMD, 32'h2);
    wait_al(1'b0, 10);
    tend("alarm command");
    // Totaliser counting and batch limit
    wr(ABC_ADR_TOT_VAL, 32'h0);
    wr(ABC_ADR_TOT_MODE, 32'h2);
    wr(ABC_ADR_TOT_ACT, 32'h1);
    wr(ABC_ADR_TOT_SAFE, 32'h0200);
    pulse_upd(32'h41200000, 1'b1);
    rd("value sum", ABC_ADR_TOT_VAL, 32'h41200000);
    cmp("upd value", 32'h41200000, upd_value_out);
    hit = 1'b1;
    pulse_upd(32'h42000000, 1'b0);
    rd("value held", ABC_ADR_TOT_VAL, 32'h41200000);
    cmp("batch bit", 32'h1, {31'h0, alarm_info_out[4]});
    cmp("tot sp", 32'h0200, {16'h0, setpoint_out});
    hit = 1'b0;
    wr(ABC_ADR_TOT_CLR, 32'h8);
    wr(ABC_ADR_RESET_CMD, 32'h1);
    cmp("cmd masked", 32'h1, {31'h0, alarm_info_out[4]});
    wr(ABC_ADR_TOT_VAL, 32'h0);
    repeat (2) @(negedge core_clk_in);
    cmp("auto clear", 32'h0, {31'h0, alarm_info_out[4]});
    cmp("sp back", 32'h0100, {16'h0, setpoint_out});
    wr(ABC_ADR_TOT_CLR, 32'h7);
    wr(ABC_ADR_RESET_CMD, 32'h4);
    rd("disable", ABC_ADR_TOT_MODE, 32'h0);
    wr(ABC_ADR_TOT_MODE, 32'h1);
    wr(ABC_ADR_TOT_VAL, 32'h40400000);
    wr(ABC_ADR_RESET_CMD, 32'h3);
    rd("cmd 3", ABC_ADR_TOT_VAL, 32'h0);
    wr(ABC_ADR_TOT_VAL, 32'h41000000);
    wr(ABC_ADR_RESET_CMD, 32'h1);
    rd("cmd 1", ABC_ADR_TOT_VAL, 32'h0);
    tend("totaliser");
    // Info flags, unit and density
    err_s = 1'b1; warn_s = 1'b1;
    @(negedge core_clk_in); err_s = 1'b0; warn_s = 1'b0;
    repeat (2) @(negedge core_clk_in);
    cmp("info set", 32'h3, {30'h0, alarm_info_out[1:0]});
    wr(ABC_ADR_RESET_CMD, 32'h6);
    cmp("cmd 6", 32'h2, {30'h0, alarm_info_out[1:0]});
    wr(ABC_ADR_RESET_CMD, 32'h7);
    cmp("cmd 7", 32'h0, {30'h0, alarm_info_out[1:0]});
    cmp("normal", 32'h0, {31'h0, upd_custom_out});
    wr(ABC_ADR_UNIT, 32'h6d6c2020);
    rd("unit", ABC_ADR_UNIT, 32'h6d6c2020);
    cmp("custom", 32'h1, {31'h0, upd_custom_out});
    wr(ABC_ADR_UNIT, 32'h67202020);
    @(negedge core_clk_in);
    cmp("mass", 32'h0, {31'h0, upd_custom_out});
    wr(ABC_ADR_DENSITY, 32'h3f000000);
    cmp("density", 32'h3f000000, upd_density_out);
    tend("info unit");
    // Retention across reset
    wr(ABC_ADR_TOT_VAL, 32'h41000000);
    nrst_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    nrst_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    rd("kept value", ABC_ADR_TOT_VAL, 32'h41000000);
    rd("kept mode", ABC_ADR_TOT_MODE, 32'h1);
    rd("clr after reset", ABC_ADR_ALM_CLR, 32'hf);
    tend("retention");
    results();
  end
endmodule

// >>> design/abc_alarm_batch.sv
`timescale 1ns/1ps
// Alarm response and batch totaliser with parameter port
module abc_alarm_batch
  import abc_pkg::*;
#(
  parameter int SEC_CYC = ABC_SEC_CYC
)(
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        par_wr_in,
  input  wire logic        par_rd_in,
  input  wire logic [15:0] par_addr_in,
  input  wire logic [31:0] par_wdata_in,
  input  wire logic        alarm_cond_in,
  input  wire logic        err_set_in,
  input  wire logic        warn_set_in,
  input  wire logic        clr_switch_in,
  input  wire logic        clr_ext_in,
  input  wire logic        upd_in,
  input  wire logic [31:0] increment_in,
  input  wire logic [31:0] sum_in,
  input  wire logic        limit_hit_in,
  input  wire logic [15:0] setpoint_in,
  output logic [31:0]      par_rdata_out,
  output logic             par_ack_out,
  output logic [15:0]      setpoint_out,
  output logic             alarm_out,
  output logic [7:0]       alarm_info_out,
  output logic             upd_req_out,
  output logic [31:0]      upd_value_out,
  output logic [31:0]      upd_density_out,
  output logic             upd_custom_out,
  output logic [31:0]      upd_limit_out
);

  typedef struct packed {
    logic        alm_act;
    logic [15:0] alm_safe;
    logic [7:0]  alm_dly;
    logic [3:0]  alm_clr;
    logic        tot_act;
    logic [15:0] tot_safe;
    logic [1:0]  tot_mode;
    logic [3:0]  tot_clr;
    logic [31:0] tot_val;
    logic [31:0] limit;
    logic [31:0] unit;
    logic [31:0] density;
    logic        restored;
    abc_alarm_e  al_st;
    logic [7:0]  sec_cnt;
    logic [31:0] cyc_cnt;
    logic        alarm;
    logic        batch;
    logic [1:0]  info_ew;
    logic [31:0] rdata;
    logic        ack;
    logic [15:0] sp;
    logic        upd_req;
    logic        custom;
  } abc_st_s;

  abc_st_s     st_r;
  abc_st_s     st_nxt;
  logic [31:0] nv_value;
  logic [1:0]  nv_mode;
  logic        nv_wr;

  // ----------------------------------------------------------------
  // Retained totaliser copy
  // ----------------------------------------------------------------
  abc_nv_store u_nv (
    .core_clk_in  (core_clk_in),
    .wr_en_in     (nv_wr),
    .wr_value_in  (st_r.tot_val),
    .wr_mode_in   (st_r.tot_mode),
    .rd_value_out (nv_value),
    .rd_mode_out  (nv_mode)
  );

  assign nv_wr = st_r.restored;

  function automatic logic [31:0] clip_f(input logic [31:0] v, input logic [31:0] mx);
    // Positive floats order like unsigned integers; sign bit clears to zero
    if (v[31])
      clip_f = 32'h0;
    else if (v > mx)
      clip_f = mx;
    else
      clip_f = v;
  endfunction

  function automatic logic [15:0] clip_sp(input logic [31:0] v);
    if (v > {16'h0, ABC_SP_MAX})
      clip_sp = ABC_SP_MAX;
    else
      clip_sp = v[15:0];
  endfunction

  logic [7:0] info;
  logic       wr_cmd;
  logic [2:0] cmd;
  logic       alm_clear;
  logic       tot_clear;
  logic       tot_reset;
  logic       sec_tick;

  // Custom volume names carry none of the letters g, n or s, wherever the padding sits
  logic [3:0] unit_std;
  for (genvar gi = 0; gi < 4; gi++) begin : g_unit
    assign unit_std[gi] = (st_r.unit[8*gi +: 8] == 8'h67) || (st_r.unit[8*gi +: 8] == 8'h6e)
                          || (st_r.unit[8*gi +: 8] == 8'h73);
  end

  always_comb begin
    st_nxt    = st_r;
    wr_cmd    = par_wr_in && (par_addr_in == ABC_ADR_RESET_CMD);
    cmd       = par_wdata_in[2:0];
    info      = 8'h0;
    tot_reset = 1'b0;
    alm_clear = 1'b0;
    tot_clear = 1'b0;
    sec_tick  = 1'b0;

    // ----------------------------------------------------------------
    // Power-up restore of the totaliser
    // ----------------------------------------------------------------
    if (!st_r.restored) begin
      st_nxt.restored = 1'b1;
      st_nxt.tot_val  = clip_f(nv_value, ABC_TOT_MAX); // R06
      st_nxt.tot_mode = (nv_mode > ABC_MODE_LIM) ? ABC_MODE_OFF : nv_mode; // R06
    end

    // ----------------------------------------------------------------
    // Parameter writes
    // ----------------------------------------------------------------
    if (par_wr_in) begin
      unique case (par_addr_in)
        ABC_ADR_ALM_ACT:  st_nxt.alm_act  = par_wdata_in[0]; // R01
        ABC_ADR_ALM_SAFE: st_nxt.alm_safe = clip_sp(par_wdata_in); // R02
        ABC_ADR_ALM_DLY:  st_nxt.alm_dly  = par_wdata_in[7:0]; // R18
        ABC_ADR_ALM_CLR:  st_nxt.alm_clr  = par_wdata_in[3:0]; // R03
        ABC_ADR_TOT_ACT:  st_nxt.tot_act  = par_wdata_in[0]; // R10
        ABC_ADR_TOT_SAFE: st_nxt.tot_safe = clip_sp(par_wdata_in); // R11
        ABC_ADR_TOT_MODE: begin
          if (par_wdata_in[7:0] <= 8'h2)
            st_nxt.tot_mode = par_wdata_in[1:0]; // R07
        end
        ABC_ADR_TOT_CLR:  st_nxt.tot_clr  = par_wdata_in[3:0]; // R12
        ABC_ADR_TOT_VAL: begin
          st_nxt.tot_val = clip_f(par_wdata_in, ABC_TOT_MAX); // R08
          tot_reset      = (par_wdata_in == 32'h0);
        end
        ABC_ADR_LIMIT:    st_nxt.limit    = clip_f(par_wdata_in, ABC_LIMIT_MAX); // R09
        ABC_ADR_UNIT:     st_nxt.unit     = par_wdata_in; // R14
        ABC_ADR_DENSITY:  st_nxt.density  = par_wdata_in; // R15
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // Reset command decode
    // ----------------------------------------------------------------
    if (wr_cmd) begin
      if ((cmd == ABC_CMD_TOT1 || cmd == ABC_CMD_TOT3 || cmd == ABC_CMD_TOT_DIS)
          && st_r.tot_clr[ABC_CLR_CMD]) begin
        st_nxt.tot_val = 32'h0; // R16
        tot_clear      = 1'b1;
        tot_reset      = 1'b1;
        if (cmd == ABC_CMD_TOT_DIS)
          st_nxt.tot_mode = ABC_MODE_OFF; // R16
      end
      if (cmd == ABC_CMD_ALARM && st_r.alm_clr[ABC_CLR_CMD])
        alm_clear = 1'b1; // R16
    end

    // Hardware switch and external line, each gated by its mask bit
    if ((clr_switch_in && st_r.alm_clr[ABC_CLR_SWITCH]) || (clr_ext_in && st_r.alm_clr[ABC_CLR_EXT]))
      alm_clear = 1'b1; // R03
    if ((clr_switch_in && st_r.tot_clr[ABC_CLR_SWITCH]) || (clr_ext_in && st_r.tot_clr[ABC_CLR_EXT]))
      tot_clear = 1'b1; // R12
    if (tot_reset && st_r.tot_clr[ABC_CLR_AUTO])
      tot_clear = 1'b1; // R13

    // ----------------------------------------------------------------
    // Error and warning flags: set wins over clear
    // ----------------------------------------------------------------
    if (wr_cmd && cmd == ABC_CMD_ERR)
      st_nxt.info_ew[0] = 1'b0; // R16
    if (wr_cmd && cmd == ABC_CMD_WARN)
      st_nxt.info_ew[1] = 1'b0; // R16
    if (err_set_in)
      st_nxt.info_ew[0] = 1'b1;
    if (warn_set_in)
      st_nxt.info_ew[1] = 1'b1;

    // ----------------------------------------------------------------
    // Alarm with delayed activation and release
    // ----------------------------------------------------------------
    st_nxt.cyc_cnt = st_r.cyc_cnt + 32'h1;
    if (st_r.cyc_cnt == 32'(SEC_CYC - 1)) begin
      st_nxt.cyc_cnt = 32'h0;
      sec_tick       = 1'b1;
    end
    unique case (st_r.al_st)
      ABC_AL_IDLE: begin
        st_nxt.sec_cnt = 8'h0;
        st_nxt.cyc_cnt = 32'h0;
        if (alarm_cond_in != st_r.alarm)
          st_nxt.al_st = ABC_AL_ARM;
      end
      ABC_AL_ARM: begin
        if (alarm_cond_in == st_r.alarm) begin
          st_nxt.al_st = ABC_AL_IDLE;
        end else if (st_r.sec_cnt >= st_r.alm_dly) begin
          st_nxt.al_st = ABC_AL_ON; // R18
        end else if (sec_tick) begin
          st_nxt.sec_cnt = st_r.sec_cnt + 8'h1;
        end
      end
      ABC_AL_ON: begin
        st_nxt.al_st = ABC_AL_IDLE;
        if (alarm_cond_in)
          st_nxt.alarm = 1'b1; // R18
        else if (st_r.alm_clr[ABC_CLR_AUTO])
          st_nxt.alarm = 1'b0; // R05
      end
      default: st_nxt.al_st = ABC_AL_IDLE;
    endcase
    // A fresh activation wins over a clear in the same cycle
    if (alm_clear && !(st_r.al_st == ABC_AL_ON && alarm_cond_in))
      st_nxt.alarm = 1'b0; // R03

    // ----------------------------------------------------------------
    // Totaliser accumulation
    // ----------------------------------------------------------------
    st_nxt.upd_req = 1'b0;
    if (st_r.restored && st_r.tot_mode != ABC_MODE_OFF && !st_r.batch && !par_wr_in && !wr_cmd) begin
      if (upd_in)
        st_nxt.upd_req = 1'b1; // R19
      if (st_r.upd_req)
        st_nxt.tot_val = clip_f(sum_in, ABC_TOT_MAX); // R19
    end
    if (st_r.restored && st_r.tot_mode == ABC_MODE_LIM && limit_hit_in)
      st_nxt.batch = 1'b1; // R20
    if (tot_clear && !(st_r.tot_mode == ABC_MODE_LIM && limit_hit_in && !tot_reset))
      st_nxt.batch = 1'b0; // R20

    // ----------------------------------------------------------------
    // Setpoint substitution and readback
    // ----------------------------------------------------------------
    if (st_r.alarm && st_r.alm_act)
      st_nxt.sp = st_r.alm_safe; // R01
    else if (st_r.batch && st_r.tot_act)
      st_nxt.sp = st_r.tot_safe; // R10
    else
      st_nxt.sp = setpoint_in;

    info[ABC_INFO_ERR]   = st_r.info_ew[0];
    info[ABC_INFO_WARN]  = st_r.info_ew[1];
    info[ABC_INFO_BATCH] = st_r.batch; // R17
    st_nxt.custom        = ~|unit_std; // R15

    st_nxt.ack   = par_rd_in | par_wr_in;
    st_nxt.rdata = 32'h0;
    if (par_rd_in) begin
      unique case (par_addr_in)
        ABC_ADR_ALM_ACT:   st_nxt.rdata = {31'h0, st_r.alm_act};
        ABC_ADR_ALM_SAFE:  st_nxt.rdata = {16'h0, st_r.alm_safe};
        ABC_ADR_ALM_DLY:   st_nxt.rdata = {24'h0, st_r.alm_dly};
        ABC_ADR_ALM_CLR:   st_nxt.rdata = {28'h0, st_r.alm_clr};
        ABC_ADR_TOT_ACT:   st_nxt.rdata = {31'h0, st_r.tot_act};
        ABC_ADR_TOT_SAFE:  st_nxt.rdata = {16'h0, st_r.tot_safe};
        ABC_ADR_TOT_MODE:  st_nxt.rdata = {30'h0, st_r.tot_mode};
        ABC_ADR_TOT_CLR:   st_nxt.rdata = {28'h0, st_r.tot_clr};
        ABC_ADR_TOT_VAL:   st_nxt.rdata = st_r.tot_val;
        ABC_ADR_LIMIT:     st_nxt.rdata = st_r.limit;
        ABC_ADR_UNIT:      st_nxt.rdata = st_r.unit;
        ABC_ADR_DENSITY:   st_nxt.rdata = st_r.density;
        ABC_ADR_ALM_INFO:  st_nxt.rdata = {24'h0, info};
        default:           st_nxt.rdata = 32'h0;
      endcase
    end

    if (!nrst_in) begin
      st_nxt          = '0;
      st_nxt.alm_clr  = ABC_ALM_CLR_RST; // R04
      st_nxt.tot_clr  = ABC_TOT_CLR_RST; // R12
      st_nxt.unit     = ABC_UNIT_RST;
      st_nxt.density  = ABC_DENSITY_RST;
      st_nxt.al_st    = ABC_AL_IDLE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    st_r <= st_nxt;
  end

  assign par_rdata_out   = st_r.rdata;
  assign par_ack_out     = st_r.ack;
  assign setpoint_out    = st_r.sp;
  assign alarm_out       = st_r.alarm;
  assign alarm_info_out  = {3'h0, st_r.batch, 2'h0, st_r.info_ew[1], st_r.info_ew[0]};
  assign upd_req_out     = st_r.upd_req;
  assign upd_value_out   = st_r.tot_val;
  assign upd_density_out = st_r.density;
  assign upd_custom_out  = st_r.custom; // R15
  assign upd_limit_out   = st_r.limit;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  chk_alarm_sp_sub: assert property (st_r.alarm && st_r.alm_act |=> setpoint_out == $past(st_r.alm_safe)) // R01
    else $error("alarm safe setpoint not applied");
  chk_safe_sp_range: assert property (st_r.alm_safe <= ABC_SP_MAX && st_r.tot_safe <= ABC_SP_MAX) // R02
    else $error("safe setpoint out of range");
  chk_clr_reset_val: assert property ($rose(nrst_in) |-> st_r.alm_clr == ABC_ALM_CLR_RST
                                      && st_r.tot_clr == ABC_TOT_CLR_RST) // R04
    else $error("clear mask reset value wrong");
  chk_auto_clear: assert property (st_r.al_st == ABC_AL_ON && !alarm_cond_in && st_r.alm_clr[ABC_CLR_AUTO]
                                   |=> !alarm_out) // R05
    else $error("automatic alarm clear missed");
  chk_mode_legal: assert property (st_r.tot_mode != 2'h3) // R07
    else $error("illegal totaliser mode");
  chk_limit_range: assert property (st_r.limit <= ABC_LIMIT_MAX && st_r.tot_val <= ABC_TOT_MAX) // R09
    else $error("float register out of range");
  chk_batch_sp_sub: assert property (st_r.batch && st_r.tot_act && !st_r.alarm |=> setpoint_out == $past(st_r.tot_safe)) // R10
    else $error("totaliser safe setpoint not applied");
  chk_cmd_disable: assert property (wr_cmd && cmd == ABC_CMD_TOT_DIS && st_r.tot_clr[ABC_CLR_CMD] && st_r.restored
                                    |=> st_r.tot_mode == ABC_MODE_OFF && st_r.tot_val == 32'h0) // R16
    else $error("reset and disable failed");
  chk_info_batch: assert property (st_r.restored && st_r.tot_mode == ABC_MODE_LIM && limit_hit_in && !tot_reset
                                   |=> alarm_info_out[ABC_INFO_BATCH]) // R17
    else $error("batch info bit not set at limit");
  chk_hold_limit: assert property (st_r.batch && !par_wr_in && !wr_cmd |=> st_r.tot_val == $past(st_r.tot_val)) // R20
    else $error("totaliser advanced past limit");

  cov_alarm_on: cover property (st_r.al_st == ABC_AL_ON ##1 alarm_out);
  cov_batch_hit: cover property ($rose(st_r.batch));
  cov_cmd_alarm: cover property (wr_cmd && cmd == ABC_CMD_ALARM && alarm_out ##1 !alarm_out);

endmodule

// >>> design/abc_nv_store.sv
`timescale 1ns/1ps
// Retained totaliser store: value and mode kept across power loss
module abc_nv_store
  import abc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        wr_en_in,
  input  wire logic [31:0] wr_value_in,
  input  wire logic [1:0]  wr_mode_in,
  output logic [31:0]      rd_value_out,
  output logic [1:0]       rd_mode_out
);

  typedef struct packed {
    logic [31:0] value;
    logic [1:0]  mode;
    logic [31:0] rd_value;
    logic [1:0]  rd_mode;
  } abc_nv_s;

  // Blank store at first power-up; never cleared by reset afterwards
  abc_nv_s st_r = '0;
  abc_nv_s st_nxt;

  // No reset on purpose: contents stand for retained storage
  always_comb begin
    st_nxt          = st_r;
    if (wr_en_in) begin
      st_nxt.value = wr_value_in;
      st_nxt.mode  = wr_mode_in;
    end
    st_nxt.rd_value = st_r.value;
    st_nxt.rd_mode  = st_r.mode;
  end

  always_ff @(posedge core_clk_in) begin
    st_r <= st_nxt;
  end

  assign rd_value_out = st_r.rd_value;
  assign rd_mode_out  = st_r.rd_mode;

endmodule

// >>> include/abc_pkg.sv
// Constants, types and functional notes for the alarm and batch totaliser block
// Functional notes
// [R01] Alarm setpoint action: 0 keeps setpoint, 1 substitutes alarm safe setpoint.
// [R02] Alarm safe setpoint 0..32000, default zero, held from activation until reset.
// [R03] Alarm clear mask bits: switch, external, reset command, automatic.
// [R04] Alarm clear mask resets to 15, all methods enabled.
// [R05] Alarm mask bit 3 clears alarm once alarm conditions vanish.
// [R06] Totaliser value and active state survive power loss and resume.
// [R07] Totaliser mode: 0 off, 1 continuous, 2 until batch limit.
// [R08] Totaliser value is read/write float, range zero to 10000000.
// [R09] Batch limit is float, zero to 9999999, default zero.
// [R10] Totaliser setpoint action: 0 keeps setpoint, 1 substitutes totaliser safe setpoint.
// [R11] Totaliser safe setpoint 0..32000, default zero, held from limit until reset.
// [R12] Totaliser clear mask same layout, resets to 7.
// [R13] Totaliser mask bit 3 clears limit condition automatically, e.g. on value reset.
// [R14] Totaliser unit is a four-character name from a fixed set.
// [R15] Custom volume unit converts mass to volume through stored density.
// [R16] Reset command: 1/3 reset totaliser, 2 alarm, 4 reset+disable, 6 error, 7 warning.
// [R17] Alarm information bit 4 set when totaliser reached batch limit.
// [R18] Alarm activation and release each delayed by 0..255 seconds, default zero.
// [R19] Each measurement update adds flow times elapsed time in selected unit.
// [R20] Limited mode stops at batch limit and holds until permitted clear.
package abc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ABC_ADR_ALM_ACT   = 16'h0c25;
  localparam logic [15:0] ABC_ADR_ALM_SAFE  = 16'h0c26;
  localparam logic [15:0] ABC_ADR_ALM_DLY   = 16'h0c27;
  localparam logic [15:0] ABC_ADR_ALM_CLR   = 16'h0c29;
  localparam logic [15:0] ABC_ADR_TOT_ACT   = 16'h0d05;
  localparam logic [15:0] ABC_ADR_TOT_SAFE  = 16'h0d06;
  localparam logic [15:0] ABC_ADR_TOT_MODE  = 16'h0d08;
  localparam logic [15:0] ABC_ADR_TOT_CLR   = 16'h0d09;
  localparam logic [15:0] ABC_ADR_RESET_CMD = 16'h0e68;
  localparam logic [15:0] ABC_ADR_ALM_INFO  = 16'h0034;
  localparam logic [15:0] ABC_ADR_TOT_VAL   = 16'he808;
  localparam logic [15:0] ABC_ADR_LIMIT     = 16'he818;
  localparam logic [15:0] ABC_ADR_UNIT      = 16'he838;
  localparam logic [15:0] ABC_ADR_DENSITY   = 16'he840;

  // ----------------------------------------------------------------
  // Reset values and ranges
  // ----------------------------------------------------------------
  localparam logic [3:0]  ABC_ALM_CLR_RST = 4'hf;
  localparam logic [3:0]  ABC_TOT_CLR_RST = 4'h7;
  localparam logic [15:0] ABC_SP_MAX      = 16'h7d00;
  // IEEE-754 single: 1.0e7 and 9999999.0
  localparam logic [31:0] ABC_TOT_MAX     = 32'h4b189680;
  localparam logic [31:0] ABC_LIMIT_MAX   = 32'h4b18967f;
  // Unit name "ln  " as packed ASCII
  localparam logic [31:0] ABC_UNIT_RST    = 32'h6c6e2020;
  localparam logic [31:0] ABC_DENSITY_RST = 32'h3f800000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ABC_CLR_SWITCH = 0;
  localparam int ABC_CLR_EXT    = 1;
  localparam int ABC_CLR_CMD    = 2;
  localparam int ABC_CLR_AUTO   = 3;
  localparam int ABC_INFO_ERR   = 0;
  localparam int ABC_INFO_WARN  = 1;
  localparam int ABC_INFO_BATCH = 4;

  localparam logic [1:0] ABC_MODE_OFF  = 2'h0;
  localparam logic [1:0] ABC_MODE_CONT = 2'h1;
  localparam logic [1:0] ABC_MODE_LIM  = 2'h2;

  localparam logic [2:0] ABC_CMD_TOT1    = 3'h1;
  localparam logic [2:0] ABC_CMD_ALARM   = 3'h2;
  localparam logic [2:0] ABC_CMD_TOT3    = 3'h3;
  localparam logic [2:0] ABC_CMD_TOT_DIS = 3'h4;
  localparam logic [2:0] ABC_CMD_ERR     = 3'h6;
  localparam logic [2:0] ABC_CMD_WARN    = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ABC_CLK_MHZ   = 200;
  localparam int ABC_SEC_US    = 1000000;
  localparam int ABC_SEC_CYC   = ABC_CLK_MHZ * ABC_SEC_US;

  typedef enum logic [2:0] {
    ABC_AL_IDLE = 3'b001,
    ABC_AL_ARM  = 3'b010,
    ABC_AL_ON   = 3'b100
  } abc_alarm_e;

endpackage
